// ===== verilog/sram_host_defines.svh
`ifndef SRAM_HOST_DEFINES_SVH
`define SRAM_HOST_DEFINES_SVH

// ----------------------------------------------------------------
// Geometry of the memory.
// ----------------------------------------------------------------
`define SRAM_ADDR_W 17
`define SRAM_DATA_W 16
`define SRAM_LANES  2

// ----------------------------------------------------------------
// Clock and timing figures in nanoseconds.
// ----------------------------------------------------------------
`define SRAM_CLK_PERIOD_NS            10
`define ADDR_TO_DATA_DELAY_FAST_NS    55
`define ADDR_TO_DATA_DELAY_SLOW_NS    70
`define ADDR_SETUP_TO_WRITE_END_FAST_NS 45
`define ADDR_SETUP_TO_WRITE_END_SLOW_NS 60
`define DATA_SETUP_TO_WRITE_END_FAST_NS 25
`define DATA_SETUP_TO_WRITE_END_SLOW_NS 30
`define STROBE_TO_HIGH_IMPEDANCE_DELAY_FAST_NS 20
`define STROBE_TO_HIGH_IMPEDANCE_DELAY_SLOW_NS 25
`define ADDRESS_HOLD_AFTER_WRITE_NS   0

// Least times round up to whole cycles.
`define SRAM_CYC_CEIL(ns) ((((ns) + `SRAM_CLK_PERIOD_NS - 1) / `SRAM_CLK_PERIOD_NS))

// ----------------------------------------------------------------
// Cycle counts derived from the figures above.
// ----------------------------------------------------------------
`define RD_CYC_FAST `SRAM_CYC_CEIL(`ADDR_TO_DATA_DELAY_FAST_NS)
`define RD_CYC_SLOW `SRAM_CYC_CEIL(`ADDR_TO_DATA_DELAY_SLOW_NS)
`define AW_CYC_FAST `SRAM_CYC_CEIL(`ADDR_SETUP_TO_WRITE_END_FAST_NS)
`define AW_CYC_SLOW `SRAM_CYC_CEIL(`ADDR_SETUP_TO_WRITE_END_SLOW_NS)
`define DS_CYC_FAST `SRAM_CYC_CEIL(`DATA_SETUP_TO_WRITE_END_FAST_NS)
`define DS_CYC_SLOW `SRAM_CYC_CEIL(`DATA_SETUP_TO_WRITE_END_SLOW_NS)
`define HZSD_CYC_FAST `SRAM_CYC_CEIL(`STROBE_TO_HIGH_IMPEDANCE_DELAY_FAST_NS + `DATA_SETUP_TO_WRITE_END_FAST_NS)
`define HZSD_CYC_SLOW `SRAM_CYC_CEIL(`STROBE_TO_HIGH_IMPEDANCE_DELAY_SLOW_NS + `DATA_SETUP_TO_WRITE_END_SLOW_NS)
`define SYNC_STAGES 2

`endif

// ===== verilog/sram_host_pkg.sv
`include "sram_host_defines.svh"

package sram_host_pkg;

  // ----------------------------------------------------------------
  // Request from the user side.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                      write;
    logic [`SRAM_LANES-1:0]    byte_en_n;
    logic [`SRAM_ADDR_W-1:0]   word_address;
    logic [`SRAM_DATA_W-1:0]   wdata;
  } mem_req_t;

  // ----------------------------------------------------------------
  // Control pins driven towards the memory.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                      chip_select_n;
    logic                      write_strobe_n;
    logic                      output_enable_n;
    logic                      upper_byte_enable_n;
    logic                      lower_byte_enable_n;
    logic [`SRAM_ADDR_W-1:0]   word_address;
  } sram_ctrl_t;

  // ----------------------------------------------------------------
  // Sequencer states.
  // ----------------------------------------------------------------
  typedef enum {
    ST_IDLE,
    ST_RD_WAIT,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_END
  } state_t;

endpackage

// ===== verilog/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Two-flop synchroniser for a bus of pin inputs.
module pin_sync #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // Pins and synchronised copy.
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  // The first stage is read only by the second.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stage1_reg   <= '0;
      pin_sync_out <= '0;
    end else begin
      stage1_reg   <= pin_in;
      pin_sync_out <= stage1_reg;
    end
  end

endmodule

`default_nettype wire

// ===== verilog/sram_host_ctrl.sv
// What this block does
// - During reads the host holds write strobe high, chip select and output enable low.
// - Host times data set-up and hold to the rising strobe ending the write.
// - Host never drives data lines while the memory may be driving them.
// - Strobe-ended write with output enable low lasts high-impedance delay plus set-up.
// - For reads the address is valid before or as chip select falls.
// - Address valid 45 or 60 ns before write end; zero set-up to start.
// - Write data valid 25 or 30 ns before the write ends.
// - Address held at least 0 ns after the write ends.
`timescale 1ns/100ps
`default_nettype none

`include "sram_host_defines.svh"

module sram_host_ctrl
  import sram_host_pkg::*;
#(
  parameter bit FAST_GRADE = 1'b1,
  parameter int ADDR_W     = `SRAM_ADDR_W,
  parameter int DATA_W     = `SRAM_DATA_W
) (
  // Clock and reset.
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  // User request port.
  input  wire logic                      req_valid,
  output logic                           req_ready,
  input  wire sram_host_pkg::mem_req_t   req,
  // User read answer.
  output logic                           rsp_valid,
  output logic [DATA_W-1:0]              rsp_rdata,
  // Memory pins.
  output sram_host_pkg::sram_ctrl_t      ctrl,
  output logic [DATA_W-1:0]              data_lines_out,
  output logic [DATA_W-1:0]              data_lines_oe,
  input  wire logic [DATA_W-1:0]         data_lines_in
);

  import sram_host_pkg::*;

  // ----------------------------------------------------------------
  // Timing counts for the selected speed grade.
  // ----------------------------------------------------------------
  localparam int RD_CYC   = FAST_GRADE ? `RD_CYC_FAST : `RD_CYC_SLOW;
  localparam int AW_CYC   = FAST_GRADE ? `AW_CYC_FAST : `AW_CYC_SLOW;
  localparam int DS_CYC   = FAST_GRADE ? `DS_CYC_FAST : `DS_CYC_SLOW;
  localparam int HZSD_CYC = FAST_GRADE ? `HZSD_CYC_FAST : `HZSD_CYC_SLOW;
  // Read strobes stay on for the access time plus synchroniser latency and one spare.
  localparam int RD_HOLD  = RD_CYC + `SYNC_STAGES + 1;
  // The strobe pulse covers address set-up less the one set-up cycle.
  localparam int WE_CYC   = (AW_CYC - 1 > DS_CYC) ? AW_CYC - 1 : DS_CYC;
  localparam int LANE_W   = DATA_W / `SRAM_LANES;

  // ----------------------------------------------------------------
  // State, timer and held request.
  // ----------------------------------------------------------------
  state_t            state_reg;
  state_t            state_next;
  logic [3:0]        cnt_reg;
  logic [3:0]        cnt_next;
  mem_req_t          req_reg;
  mem_req_t          req_next;
  sram_ctrl_t        ctrl_next;
  logic [DATA_W-1:0] data_oe_next;
  logic [DATA_W-1:0] data_sync;

  wire req_take  = req_valid && (state_reg == ST_IDLE);
  wire cnt_zero  = (cnt_reg == 4'h0);
  wire rd_done   = (state_reg == ST_RD_WAIT) && cnt_zero;

  // A request is taken only while the sequencer is idle.
  assign req_ready = (state_reg == ST_IDLE);
  assign req_next  = req_take ? req : req_reg;

  // Sequencer transitions and timer loads.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_zero ? 4'h0 : cnt_reg - 4'h1;
    unique case (state_reg)
      ST_IDLE: begin
        if (req_valid && req.write) begin
          state_next = ST_WR_SETUP;
        end else if (req_valid) begin
          state_next = ST_RD_WAIT;
          cnt_next   = 4'(RD_HOLD - 1);
        end
      end
      ST_RD_WAIT: begin
        if (cnt_zero) begin
          state_next = ST_IDLE;
        end
      end
      ST_WR_SETUP: begin
        state_next = ST_WR_PULSE;
        cnt_next   = 4'(WE_CYC - 1);
      end
      ST_WR_PULSE: begin
        if (cnt_zero) begin
          state_next = ST_WR_END;
        end
      end
      ST_WR_END: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Pin decode from the next state, registered below.
  // ----------------------------------------------------------------
  wire sel_next   = (state_next == ST_RD_WAIT) || (state_next == ST_WR_SETUP) ||
                    (state_next == ST_WR_PULSE);
  wire pulse_next = (state_next == ST_WR_PULSE);
  wire drive_next = (state_next == ST_WR_PULSE) || (state_next == ST_WR_END);

  // Strobes rise together at write end; output enable only in reads.
  assign ctrl_next.chip_select_n       = !sel_next;
  assign ctrl_next.write_strobe_n      = !pulse_next;
  assign ctrl_next.output_enable_n     = !(state_next == ST_RD_WAIT);
  assign ctrl_next.upper_byte_enable_n = sel_next ? req_next.byte_en_n[1] : 1'b1;
  assign ctrl_next.lower_byte_enable_n = sel_next ? req_next.byte_en_n[0] : 1'b1;
  // Address is set with chip select, a cycle before the write strobe falls, and held through the end cycle.
  assign ctrl_next.word_address        = req_next.word_address;

  // Each lane is driven only when its byte enable is active.
  for (genvar l = 0; l < `SRAM_LANES; l++) begin : g_lane
    assign data_oe_next[l*LANE_W +: LANE_W] =
      {LANE_W{drive_next && !req_next.byte_en_n[l]}};
  end

  // Data lines from the memory pass two flops first.
  pin_sync #(
    .WIDTH (DATA_W)
  ) u_data_sync (
    .core_clk     (core_clk),
    .rstn         (rstn),
    .pin_in       (data_lines_in),
    .pin_sync_out (data_sync)
  );

  // Read data of disabled lanes returns zero.
  wire [DATA_W-1:0] rd_masked = data_sync & ~data_oe_mask(req_reg.byte_en_n);

  function automatic logic [DATA_W-1:0] data_oe_mask(input logic [`SRAM_LANES-1:0] be_n);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < `SRAM_LANES; i++) begin
      m[i*LANE_W +: LANE_W] = {LANE_W{be_n[i]}};
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  // Sequencer and held request.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
      req_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      req_reg   <= req_next;
    end
  end

  // Memory pins; deselected and released in reset.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl           <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, '0};
      data_lines_out <= '0;
      data_lines_oe  <= '0;
    end else begin
      ctrl           <= ctrl_next;
      data_lines_out <= req_next.wdata;
      data_lines_oe  <= data_oe_next;
    end
  end

  // Read answer, one pulse at the end of the access.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= rd_done;
      if (rd_done) begin
        rsp_rdata <= rd_masked;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks on the pins this block drives.
  // ----------------------------------------------------------------
  logic [3:0] pulse_cnt;
  logic [3:0] cycle_cnt;

  // Length of the current strobe pulse and of the selected period.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pulse_cnt <= 4'h0;
      cycle_cnt <= 4'h0;
    end else begin
      pulse_cnt <= ctrl.write_strobe_n ? 4'h0 : pulse_cnt + 4'h1;
      cycle_cnt <= ctrl.chip_select_n ? 4'h0 : cycle_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence rd_open;
    $fell(ctrl.output_enable_n);
  endsequence

  sequence rd_body;
    (ctrl.write_strobe_n && !ctrl.chip_select_n && !ctrl.output_enable_n) [*8];
  endsequence

  sequence wr_close;
    $rose(ctrl.write_strobe_n);
  endsequence

  read_strobes_a : assert property (rd_open |-> rd_body)
    else $error("Read strobes not held for the access.");

  read_addr_a : assert property (
    (!ctrl.chip_select_n && $past(!ctrl.chip_select_n)) |-> $stable(ctrl.word_address))
    else $error("Address moved while selected.");

  write_end_a : assert property (
    wr_close |-> $rose(ctrl.chip_select_n) && $stable(data_lines_out) && $stable(data_lines_oe))
    else $error("Write not ended by both strobes with data held.");

  no_bus_fight_a : assert property ((|data_lines_oe) |-> ctrl.output_enable_n)
    else $error("Host drives data while memory output enabled.");

  write_cycle_len_a : assert property (
    wr_close |-> ($past(cycle_cnt) + 4'h1) >= 4'(HZSD_CYC))
    else $error("Write cycle shorter than turnaround plus set-up.");

  addr_setup_a : assert property (
    wr_close |-> ($past(cycle_cnt) + 4'h1) >= 4'(AW_CYC))
    else $error("Address set-up to write end too short.");

  data_setup_a : assert property (
    wr_close |-> (pulse_cnt >= 4'(DS_CYC)) && $stable(data_lines_out))
    else $error("Data set-up to write end too short.");

  addr_hold_a : assert property (wr_close |-> $stable(ctrl.word_address))
    else $error("Address not held at write end.");

endmodule

`default_nettype wire

// ===== sim/sram_model.sv
`timescale 1ns/100ps
`default_nettype none

// Behavioural memory standing on the far side of the controller.
module sram_model
  import sram_host_pkg::*;
#(
  parameter int T_AA  = 55,
  parameter int DATA_HOLD_AFTER_ADDRESS = 10
) (
  // Control pins from the host.
  input  wire sram_host_pkg::sram_ctrl_t ctrl,
  // Resolved data lines and the memory's own drive.
  input  wire logic [15:0]               bus_in,
  output logic      [15:0]               drv_data,
  output logic      [15:0]               drv_en
);
  logic [15:0] mem [0:131071];
  logic        wr_on = 1'b0;
  logic [16:0] wa;
  logic [1:0]  wbe;
  logic [15:0] wd;
  logic        rd_on;

  initial drv_data = 16'h0;

  // The memory drives only in a read, and only on the enabled byte lanes.
  assign rd_on  = !ctrl.chip_select_n && ctrl.write_strobe_n && !ctrl.output_enable_n;
  assign drv_en = rd_on ? {{8{!ctrl.upper_byte_enable_n}}, {8{!ctrl.lower_byte_enable_n}}}
                        : 16'h0;

  // Old data holds briefly after an address change, then garbage, then the new word.
  always @(ctrl.word_address or rd_on) begin
    drv_data <= #(DATA_HOLD_AFTER_ADDRESS) ~drv_data;
    drv_data <= #(T_AA) mem[ctrl.word_address];
  end

  // A write follows the bus while both strobes are low and commits when either rises.
  always @(ctrl or bus_in) begin
    if (!ctrl.chip_select_n && !ctrl.write_strobe_n) begin
      wr_on = 1'b1;
      wa    = ctrl.word_address;
      wbe   = {ctrl.upper_byte_enable_n, ctrl.lower_byte_enable_n};
      wd    = bus_in;
    end else if (wr_on) begin
      if (!wbe[0]) mem[wa][7:0] = wd[7:0];
      if (!wbe[1]) mem[wa][15:8] = wd[15:8];
      wr_on = 1'b0;
    end
  end
endmodule

`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import sram_host_pkg::*;

  localparam int RD_HOLD = 9;  // Six cycles of access, two for the synchroniser and one spare.
  // Least figures of the fast grade, in nanoseconds, and the clock period.
  localparam int T_CLK_NS = 10;
  localparam int T_RC_NS  = 55;
  localparam int T_AW_NS  = 45;
  localparam int T_SD_NS  = 25;

  logic        core_clk  = 1'b0;
  logic        rstn      = 1'b0;
  logic        req_valid = 1'b0;
  mem_req_t    req       = '0;
  logic        req_ready;
  logic        rsp_valid;
  logic [15:0] rsp_rdata;
  sram_ctrl_t  ctrl;
  logic [15:0] data_lines_out;
  logic [15:0] data_lines_oe;
  logic [15:0] data_lines_in;
  logic [15:0] drv_data;
  logic [15:0] drv_en;
  logic [15:0] float_pat = 16'h5a5a;
  logic [15:0] shadow [logic [16:0]];
  logic [16:0] addrs [4];
  logic [15:0] exp_q [$];
  int unsigned due_q [$];
  int unsigned cyc    = 0;
  int          we_len = 0;
  int          cs_len = 0;
  int          num_errors = 0;
  int          tests_run  = 0;
  integer      seed       = 32'h740d;
  logic [31:0] r;

  always #5 core_clk = ~core_clk;

  // Cycle count, and a floating pattern that changes each cycle on released lines.
  always @(posedge core_clk) begin
    cyc       <= cyc + 1;
    float_pat <= ~float_pat;
  end

  // Wire level of the shared data lines.
  assign data_lines_in = (data_lines_oe & data_lines_out) | (~data_lines_oe & drv_en & drv_data)
                       | (~data_lines_oe & ~drv_en & float_pat);

  sram_host_ctrl #(.FAST_GRADE(1'b1)) i_dut (
    .core_clk       (core_clk),
    .rstn           (rstn),
    .req_valid      (req_valid),
    .req_ready      (req_ready),
    .req            (req),
    .rsp_valid      (rsp_valid),
    .rsp_rdata      (rsp_rdata),
    .ctrl           (ctrl),
    .data_lines_out (data_lines_out),
    .data_lines_oe  (data_lines_oe),
    .data_lines_in  (data_lines_in)
  );

  sram_model i_mem (
    .ctrl     (ctrl),
    .bus_in   (data_lines_in),
    .drv_data (drv_data),
    .drv_en   (drv_en)
  );

  // ----------------------------------------------------------------
  // Comparison, verdict and request tasks.
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors=%0d compares=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic logic [15:0] lanes(input logic [1:0] be);
    lanes = {{8{!be[1]}}, {8{!be[0]}}};
  endfunction

  // Presents one request at a falling edge, holds it until taken, notes the expectation.
  task automatic do_req(input logic wr, input logic [1:0] be, input logic [16:0] a,
                        input logic [15:0] d);
    logic [15:0] m;
    m         = lanes(be);
    req_valid = 1'b1;
    req       = '{wr, be, a, d};
    while (req_ready !== 1'b1) @(negedge core_clk);
    if (wr) begin
      shadow[a] = (shadow[a] & ~m) | (d & m);
    end else begin
      exp_q.push_back(shadow[a] & m);
      due_q.push_back(cyc + 1 + RD_HOLD);
    end
    @(negedge core_clk);
  endtask

  // Watches the pins every cycle and matches each read answer to the oldest note.
  always @(negedge core_clk) begin
    if (rstn) begin
      check(data_lines_oe & drv_en, 16'h0);
      check(ctrl.output_enable_n | ctrl.write_strobe_n, 1'b1);
      if (!ctrl.chip_select_n) begin
        cs_len++;
        we_len += int'(!ctrl.write_strobe_n);
      end else if (cs_len != 0) begin
        if (we_len != 0) begin
          check(cs_len * T_CLK_NS >= T_AW_NS, 1'b1);
          check(we_len * T_CLK_NS >= T_SD_NS, 1'b1);
        end else begin
          check(cs_len * T_CLK_NS >= T_RC_NS, 1'b1);
        end
        cs_len = 0;
        we_len = 0;
      end
      if (rsp_valid === 1'b1) begin
        if (exp_q.size() == 0) begin
          check(rsp_valid, 1'b0);
        end else begin
          check(rsp_rdata, exp_q.pop_front());
          check(cyc, due_q.pop_front());
        end
      end
    end
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    check(ctrl, {5'h1f, 17'h0});
    check({data_lines_oe, req_ready, rsp_valid}, {16'h0, 2'h2});
    rstn     = 1'b1;
    addrs[0] = 17'h0;
    addrs[1] = 17'h1ffff;
    addrs[2] = 17'($random(seed));
    addrs[3] = 17'($random(seed));
    // Full words first, then every lane code back to back, then every read code.
    for (int i = 0; i < 4; i++) do_req(1'b1, 2'h0, addrs[i], 16'($random(seed)));
    for (int i = 0; i < 4; i++) do_req(1'b1, i[1:0], addrs[i], 16'($random(seed)));
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 4; j++) do_req(1'b0, j[1:0], addrs[i], 16'h0);
    end
    // Random mix of reads and writes.
    repeat (40) begin
      r = $random(seed);
      do_req(r[0], r[2:1], addrs[r[4:3]], r[23:8]);
    end
    req_valid = 1'b0;
    for (int k = 0; k < 50 && exp_q.size() != 0; k++) @(negedge core_clk);
    check(exp_q.size(), 0);
    end_of_test();
  end
endmodule

`default_nettype wire
